// [rtl/static_mem_ctrl.v]
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "static_mem_ctrl_defines.vh"

// Behaviour
// - Eight RW config registers, reset 0x00002000
// - Wait count sets strobe pulse length
// - Wait count reads zero when disabled
// - Pulse lengths per protocol and count
// - Bit 7 enables programmed wait states
// - Bus held for data float cycles
// - Byte access type only for 16-bit
// - Bus width codes 01=16, 10=8
// - Bit 15 selects early read protocol
// - Chip select shortened both ends
// - Setup N plus half cycle, zero for early read at N=0
// - Hold N cycles, zero special cases
module static_mem_ctrl #(
  parameter NUM_CS = 8
) (
  ref_clk,
  srst,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  acc_req,
  acc_cs,
  acc_write,
  acc_ready,
  acc_done,
  chip_select_n,
  read_strobe_n,
  write_strobe_n,
  bus_width_16,
  bus_width_8,
  byte_access_type,
  bus_busy
);
  input  wire              ref_clk;
  input  wire              srst;
  input  wire              hsel;
  input  wire [31:0]       haddr;
  input  wire [1:0]        htrans;
  input  wire              hwrite;
  input  wire [2:0]        hsize;
  input  wire [31:0]       hwdata;
  input  wire              hready;
  output wire              hreadyout;
  output wire              hresp;
  output reg  [31:0]       hrdata;
  input  wire              acc_req;
  input  wire [2:0]        acc_cs;
  input  wire              acc_write;
  output wire              acc_ready;
  output reg               acc_done;
  output reg  [NUM_CS-1:0] chip_select_n;
  output reg               read_strobe_n;
  output reg               write_strobe_n;
  output reg               bus_width_16;
  output reg               bus_width_8;
  output reg               byte_access_type;
  output wire              bus_busy;

  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_ACCESS = 3'h2;
  localparam [2:0] ST_FLOAT  = 3'h4;

  // Bus slave
  reg                    wr_pend_reg;
  reg  [2:0]             wr_idx_reg;
  wire                   addr_phase;
  wire                   addr_hit;
  wire [2:0]             addr_idx;
  wire [31:0]            cfg_flat  [0:NUM_CS-1];
  wire [31:0]            rd_flat   [0:NUM_CS-1];
  wire [31:0]            fwd_view;

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign addr_hit   = (haddr[31:5] == 27'h0000000) &
                      (haddr[1:0] == 2'h0);
  assign addr_idx   = haddr[4:2];

  always @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 3'h0;
    end else begin
      wr_pend_reg <= addr_phase & addr_hit & hwrite &
                     (hsize == `HSIZE_WORD);
      wr_idx_reg  <= addr_idx;
    end
  end

  // Read view of a word being written this cycle
  assign fwd_view = hwdata[`WS_ENABLE_BIT] ?
                    (hwdata & `CS_CONFIG_MASK) :
                    ({hwdata[31:`WS_COUNT_MSB+1], 7'h00} &
                     `CS_CONFIG_MASK);

  always @(posedge ref_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      if (~addr_hit) begin
        hrdata <= 32'h00000000;
      end else if (wr_pend_reg & (wr_idx_reg == addr_idx)) begin
        hrdata <= fwd_view;
      end else begin
        hrdata <= rd_flat[addr_idx];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi = gi + 1) begin : g_cfg
      cs_config_reg u_cfg (
        .ref_clk (ref_clk),
        .srst    (srst),
        .wr_en   (wr_pend_reg & (wr_idx_reg == gi)),
        .wdata   (hwdata),
        .cfg_q   (cfg_flat[gi]),
        .rd_data (rd_flat[gi])
      );
    end
  endgenerate

  // Field decode of the selected chip select
  wire [31:0] sel_cfg;
  wire [6:0]  f_ws_count;
  wire        f_ws_en;
  wire [3:0]  f_float;
  wire        f_bat;
  wire [1:0]  f_width;
  wire        f_early;
  wire [1:0]  f_shorten;
  wire [2:0]  f_setup;
  wire [2:0]  f_hold;

  assign sel_cfg    = cfg_flat[acc_cs];
  assign f_ws_count = sel_cfg[`WS_COUNT_MSB:`WS_COUNT_LSB];
  assign f_ws_en    = sel_cfg[`WS_ENABLE_BIT];
  assign f_float    = sel_cfg[`FLOAT_MSB:`FLOAT_LSB];
  assign f_bat      = sel_cfg[`BYTE_ACCESS_BIT];
  assign f_width    = sel_cfg[`BUS_WIDTH_MSB:`BUS_WIDTH_LSB];
  assign f_early    = sel_cfg[`READ_PROTO_BIT];
  assign f_shorten  = sel_cfg[`CS_SHORTEN_MSB:`CS_SHORTEN_LSB];
  assign f_setup    = sel_cfg[`SETUP_MSB:`SETUP_LSB];
  assign f_hold     = sel_cfg[`HOLD_MSB:`HOLD_LSB];

  // Phase lengths in half-cycle ticks
  reg [9:0] setup_len;
  reg [9:0] pulse_len;
  reg [9:0] hold_len;
  reg [9:0] float_len;
  reg [9:0] short_len;
  wire      rd_early;

  assign rd_early = f_early & ~acc_write;

  always @* begin
    if (f_setup != 3'h0) begin
      setup_len = {6'h00, f_setup, 1'b0} + `HALF_TICK;
    end else if (rd_early) begin
      setup_len = 10'h000;
    end else begin
      setup_len = `HALF_TICK;
    end
    if (~f_ws_en) begin
      pulse_len = rd_early ? `TICKS_PER_CYCLE : `HALF_TICK;
    end else if (acc_write) begin
      pulse_len = {2'h0, f_ws_count, 1'b0} + `TICKS_PER_CYCLE;
    end else if (rd_early) begin
      pulse_len = {2'h0, f_ws_count, 1'b0} + `TICKS_PER_CYCLE +
                  `TICKS_PER_CYCLE;
    end else begin
      pulse_len = {2'h0, f_ws_count, 1'b0} + `TICKS_PER_CYCLE +
                  `HALF_TICK;
    end
    if (f_hold != 3'h0) begin
      hold_len = {6'h00, f_hold, 1'b0};
    end else begin
      hold_len = acc_write ? `HALF_TICK : 10'h000;
    end
    float_len = {5'h00, f_float, 1'b0};
    short_len = {7'h00, f_shorten, 1'b0};
  end

  // Access sequencer
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [9:0]  pos_reg;
  reg  [9:0]  pos_next;
  reg  [2:0]  cur_cs_reg;
  reg  [2:0]  cur_cs_next;
  reg         cur_wr_reg;
  reg         cur_wr_next;
  reg  [9:0]  strb_beg_reg;
  reg  [9:0]  strb_beg_next;
  reg  [9:0]  strb_end_reg;
  reg  [9:0]  strb_end_next;
  reg  [9:0]  total_reg;
  reg  [9:0]  total_next;
  reg  [9:0]  short_reg;
  reg  [9:0]  short_next;
  reg  [9:0]  float_reg;
  reg  [9:0]  float_next;
  reg         done_next;
  wire        accept;

  // Float time blocks every other chip select
  assign acc_ready = (state_reg == ST_IDLE) |
                     ((state_reg == ST_FLOAT) & (acc_cs == cur_cs_reg));
  assign accept    = acc_req & acc_ready;
  assign bus_busy  = (state_reg != ST_IDLE);

  always @* begin
    state_next    = state_reg;
    pos_next      = pos_reg;
    cur_cs_next   = cur_cs_reg;
    cur_wr_next   = cur_wr_reg;
    strb_beg_next = strb_beg_reg;
    strb_end_next = strb_end_reg;
    total_next    = total_reg;
    short_next    = short_reg;
    float_next    = float_reg;
    done_next     = 1'b0;
    case (state_reg)
      ST_IDLE, ST_FLOAT: begin
        if (accept) begin
          state_next    = ST_ACCESS;
          pos_next      = 10'h000;
          cur_cs_next   = acc_cs;
          cur_wr_next   = acc_write;
          strb_beg_next = setup_len;
          strb_end_next = setup_len + pulse_len;
          total_next    = setup_len + pulse_len + hold_len;
          short_next    = short_len;
          float_next    = float_len;
        end else if (state_reg == ST_FLOAT) begin
          if (pos_reg + 10'h001 >= float_reg) begin
            state_next = ST_IDLE;
            pos_next   = 10'h000;
          end else begin
            pos_next = pos_reg + 10'h001;
          end
        end
      end
      ST_ACCESS: begin
        if (pos_reg + 10'h001 >= total_reg) begin
          done_next  = 1'b1;
          pos_next   = 10'h000;
          state_next = (float_reg != 10'h000) ? ST_FLOAT : ST_IDLE;
        end else begin
          pos_next = pos_reg + 10'h001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        pos_next   = 10'h000;
      end
    endcase
  end

  // Strobe and chip select windows for the next tick
  wire in_acc_next;
  wire strb_on_next;
  wire cs_on_next;

  assign in_acc_next  = (state_next == ST_ACCESS);
  assign strb_on_next = in_acc_next & (pos_next >= strb_beg_next) &
                        (pos_next < strb_end_next);
  assign cs_on_next   = in_acc_next & (pos_next >= short_next) &
                        (pos_next + short_next < total_next);

  always @(posedge ref_clk) begin
    if (srst) begin
      state_reg        <= ST_IDLE;
      pos_reg          <= 10'h000;
      cur_cs_reg       <= 3'h0;
      cur_wr_reg       <= 1'b0;
      strb_beg_reg     <= 10'h000;
      strb_end_reg     <= 10'h000;
      total_reg        <= 10'h000;
      short_reg        <= 10'h000;
      float_reg        <= 10'h000;
      acc_done         <= 1'b0;
      chip_select_n    <= {NUM_CS{1'b1}};
      read_strobe_n    <= 1'b1;
      write_strobe_n   <= 1'b1;
      bus_width_16     <= 1'b0;
      bus_width_8      <= 1'b0;
      byte_access_type <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pos_reg        <= pos_next;
      cur_cs_reg     <= cur_cs_next;
      cur_wr_reg     <= cur_wr_next;
      strb_beg_reg   <= strb_beg_next;
      strb_end_reg   <= strb_end_next;
      total_reg      <= total_next;
      short_reg      <= short_next;
      float_reg      <= float_next;
      acc_done       <= done_next;
      chip_select_n  <= ~({{(NUM_CS-1){1'b0}}, cs_on_next} << cur_cs_next);
      read_strobe_n  <= ~(strb_on_next & ~cur_wr_next);
      write_strobe_n <= ~(strb_on_next & cur_wr_next);
      if (accept) begin
        bus_width_16     <= (f_width == `BUS_WIDTH_16);
        bus_width_8      <= (f_width == `BUS_WIDTH_8);
        byte_access_type <= (f_width == `BUS_WIDTH_16) & f_bat;
      end
    end
  end
endmodule

// [rtl/static_mem_ctrl_defines.vh]
`ifndef STATIC_MEM_CTRL_DEFINES_VH
`define STATIC_MEM_CTRL_DEFINES_VH

// Register map, byte addresses
`define CS_CONFIG_0_OFF     8'h00
`define CS_CONFIG_1_OFF     8'h04
`define CS_CONFIG_2_OFF     8'h08
`define CS_CONFIG_3_OFF     8'h0C
`define CS_CONFIG_4_OFF     8'h10
`define CS_CONFIG_5_OFF     8'h14
`define CS_CONFIG_6_OFF     8'h18
`define CS_CONFIG_7_OFF     8'h1C
`define CS_CONFIG_LAST_OFF  `CS_CONFIG_7_OFF
`define CS_CONFIG_RESET     32'h00002000
`define CS_CONFIG_MASK      32'h7703FFFF

// Field positions
`define WS_COUNT_LSB        0
`define WS_COUNT_MSB        6
`define WS_ENABLE_BIT       7
`define FLOAT_LSB           8
`define FLOAT_MSB           11
`define BYTE_ACCESS_BIT     12
`define BUS_WIDTH_LSB       13
`define BUS_WIDTH_MSB       14
`define READ_PROTO_BIT      15
`define CS_SHORTEN_LSB      16
`define CS_SHORTEN_MSB      17
`define SETUP_LSB           24
`define SETUP_MSB           26
`define HOLD_LSB            28
`define HOLD_MSB            30

// Bus width codes
`define BUS_WIDTH_16        2'h1
`define BUS_WIDTH_8         2'h2

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT   1
`define HSIZE_WORD          3'h2

// Timing, in half-cycle ticks of the memory bus (one ref_clk per tick)
`define TICKS_PER_CYCLE     10'h002
`define HALF_TICK           10'h001
`define EARLY_READ_EXTRA    10'h001

`endif

// [rtl/cs_config_reg.v]
`timescale 1ns/1ps
`include "static_mem_ctrl_defines.vh"

module cs_config_reg (
  ref_clk,
  srst,
  wr_en,
  wdata,
  cfg_q,
  rd_data
);
  input  wire        ref_clk;
  input  wire        srst;
  input  wire        wr_en;
  input  wire [31:0] wdata;
  output wire [31:0] cfg_q;
  output wire [31:0] rd_data;

  reg [31:0] cfg_reg;

  // Reset decodes to 16-bit bus, no waits, standard read
  always @(posedge ref_clk) begin
    if (srst) begin
      cfg_reg <= `CS_CONFIG_RESET;
    end else if (wr_en) begin
      cfg_reg <= wdata & `CS_CONFIG_MASK;
    end
  end

  assign cfg_q = cfg_reg;

  // Wait count reads zero while waits are disabled
  assign rd_data = cfg_reg[`WS_ENABLE_BIT] ? cfg_reg :
                   {cfg_reg[31:`WS_COUNT_MSB+1], 7'h00};
endmodule

// [sim/static_mem_ctrl_monitor.sv]
`timescale 1ns/1ps
// Protocol checker for the static memory controller ports
module static_mem_ctrl_monitor #(
  parameter NUM_CS = 8
) (
  input wire              ref_clk,
  input wire              srst,
  input wire              hsel,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire              hready,
  input wire              hreadyout,
  input wire              hresp,
  input wire [31:0]       hrdata,
  input wire              acc_done,
  input wire [NUM_CS-1:0] chip_select_n,
  input wire              read_strobe_n,
  input wire              write_strobe_n,
  input wire              bus_width_16,
  input wire              bus_width_8,
  input wire              byte_access_type,
  input wire              bus_busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // Register read taken in this cycle
  sequence s_rd;
    hsel && htrans[1] && !hwrite && hready;
  endsequence

  sequence s_drive;
    !read_strobe_n || !write_strobe_n || !(&chip_select_n);
  endsequence

  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RSV_ZERO: assert property (s_rd |=>
    (hrdata & ~32'h7703FFFF) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_WAIT_HIDE: assert property (s_rd |=>
    hrdata[7] || hrdata[6:0] == 7'h0)
    else $error("wait count visible while disabled");
  AST_ONE_STROBE: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  AST_ONE_CS: assert property ($onehot0(~chip_select_n))
    else $error("two chip selects low");
  AST_BUSY: assert property (s_drive |-> bus_busy)
    else $error("bus driven while not busy");
  AST_WIDTH: assert property (!(bus_width_16 && bus_width_8))
    else $error("both width flags high");
  AST_BAT: assert property (byte_access_type |-> bus_width_16)
    else $error("byte access type without 16-bit bus");
  AST_DONE: assert property (acc_done |=> !acc_done ##1 !acc_done)
    else $error("done pulse too long or too close");
  AST_RESET: assert property ($past(srst) |-> (&chip_select_n)
    && !bus_busy && read_strobe_n && write_strobe_n)
    else $error("outputs not idle after reset");
endmodule

bind static_mem_ctrl static_mem_ctrl_monitor #(
  .NUM_CS (NUM_CS)
) u_mon (
  .ref_clk          (ref_clk),
  .srst             (srst),
  .hsel             (hsel),
  .htrans           (htrans),
  .hwrite           (hwrite),
  .hready           (hready),
  .hreadyout        (hreadyout),
  .hresp            (hresp),
  .hrdata           (hrdata),
  .acc_done         (acc_done),
  .chip_select_n    (chip_select_n),
  .read_strobe_n    (read_strobe_n),
  .write_strobe_n   (write_strobe_n),
  .bus_width_16     (bus_width_16),
  .bus_width_8      (bus_width_8),
  .byte_access_type (byte_access_type),
  .bus_busy         (bus_busy)
);

// [sim/mem_model.sv]
`timescale 1ns/1ps
// External static memory: measures strobe and select low times
module mem_model (
  input wire       ref_clk,
  input wire [7:0] chip_select_n,
  input wire       read_strobe_n,
  input wire       write_strobe_n,
  output int       rd_len,
  output int       wr_len,
  output int       cs_len
);
  int r = 0;
  int w = 0;
  int c = 0;

  always @(posedge ref_clk) begin
    r <= read_strobe_n ? 0 : r + 1;
    w <= write_strobe_n ? 0 : w + 1;
    c <= (&chip_select_n) ? 0 : c + 1;
    if (!read_strobe_n) rd_len <= r + 1;
    if (!write_strobe_n) wr_len <= w + 1;
    if (!(&chip_select_n)) cs_len <= c + 1;
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        acc_req = 1'b0;
  logic        acc_write = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  acc_cs = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire         hready, hreadyout, hresp, acc_ready, acc_done, bus_busy;
  wire         read_strobe_n, write_strobe_n, byte_access_type;
  wire         bus_width_16, bus_width_8;
  wire  [31:0] hrdata;
  wire  [7:0]  chip_select_n;
  int          rd_len, wr_len, cs_len;
  int          fails = 0;
  int          num_checks = 0;

  assign hready = hreadyout;
  always #25 ref_clk = ~ref_clk;

  static_mem_ctrl u_static_mem_ctrl (
    .ref_clk          (ref_clk),
    .srst             (srst),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hready),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .acc_req          (acc_req),
    .acc_cs           (acc_cs),
    .acc_write        (acc_write),
    .acc_ready        (acc_ready),
    .acc_done         (acc_done),
    .chip_select_n    (chip_select_n),
    .read_strobe_n    (read_strobe_n),
    .write_strobe_n   (write_strobe_n),
    .bus_width_16     (bus_width_16),
    .bus_width_8      (bus_width_8),
    .byte_access_type (byte_access_type),
    .bus_busy         (bus_busy)
  );
  mem_model u_mem_model (
    .ref_clk        (ref_clk),
    .chip_select_n  (chip_select_n),
    .read_strobe_n  (read_strobe_n),
    .write_strobe_n (write_strobe_n),
    .rd_len         (rd_len),
    .wr_len         (wr_len),
    .cs_len         (cs_len)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge ref_clk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hready);
    rd = hrdata;
  endtask

  // Program one chip select, run one access, compare the timing
  task automatic run(input logic [2:0] c, input logic [31:0] v,
                     input logic w, input int sl, tot, csl, bsy,
                     input logic [2:0] fl);
    int lat;
    int busy;
    logic [2:0] f;
    logic [7:0] sel;
    ahb(1'b1, {27'h0, c, 2'h0}, v);
    acc_req <= 1'b1;
    acc_cs <= c;
    acc_write <= w;
    do @(negedge ref_clk); while (!acc_ready);
    @(posedge ref_clk);
    acc_req <= 1'b0;
    lat = 0;
    busy = 0;
    f = 3'h0;
    sel = 8'h00;
    for (int n = 1; n < 600 && !(lat != 0 && !bus_busy); n++) begin
      @(negedge ref_clk);
      if (acc_done && lat == 0) begin
        lat = n - 1;
        f = {bus_width_16, bus_width_8, byte_access_type};
      end
      busy += bus_busy;
      sel = sel | ~chip_select_n;
    end
    @(posedge ref_clk);
    check(w ? wr_len : rd_len, sl);
    check(lat, tot);
    check(cs_len, csl);
    check(busy, bsy);
    check({29'h0, f}, {29'h0, fl});
    check({24'h0, sel}, {24'h0, 8'h01 << c});
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #2000000;
    fails++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      ahb(1'b0, 32'(i * 4), 32'h0);
      check(rd, i < 8 ? 32'h00002000 : 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      ahb(1'b1, 32'(i * 4), 32'hFFFFFFFF);
      ahb(1'b0, 32'(i * 4), 32'h0);
      check(rd, i < 8 ? 32'h7703FFFF : 32'h0);
      ahb(1'b1, 32'(i * 4), 32'h0000007F);
      ahb(1'b0, 32'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    $display("test register access done");
    // Setup and hold stay zero in early read; waits exceed shortening by three
    run(3'h0, 32'h00002000, 1'b0, 1, 2, 2, 2, 3'h4);
    run(3'h1, 32'h00002000, 1'b1, 1, 3, 3, 3, 3'h4);
    run(3'h2, 32'h0000A000, 1'b0, 2, 2, 2, 2, 3'h4);
    run(3'h3, 32'h00002083, 1'b0, 9, 10, 10, 10, 3'h4);
    run(3'h4, 32'h00002083, 1'b1, 8, 10, 10, 10, 3'h4);
    run(3'h5, 32'h0000A083, 1'b0, 10, 10, 10, 10, 3'h4);
    run(3'h6, 32'h32002000, 1'b1, 1, 12, 12, 12, 3'h4);
    run(3'h7, 32'h32002000, 1'b0, 1, 12, 12, 12, 3'h4);
    run(3'h0, 32'h00012084, 1'b0, 11, 12, 8, 12, 3'h4);
    run(3'h1, 32'h00004000, 1'b1, 1, 3, 3, 3, 3'h2);
    run(3'h2, 32'h00003000, 1'b1, 1, 3, 3, 3, 3'h5);
    run(3'h3, 32'h00005000, 1'b1, 1, 3, 3, 3, 3'h2);
    run(3'h4, 32'h00000000, 1'b1, 1, 3, 3, 3, 3'h0);
    run(3'h6, 32'h00006000, 1'b1, 1, 3, 3, 3, 3'h0);
    run(3'h5, 32'h00002300, 1'b0, 1, 2, 2, 8, 3'h4);
    $display("test access timing done");
    final_report();
  end
endmodule
